// ==== plo_pkg.sv ====
// constants and types for the crosspoint partition-label override block
package plo_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int PLO_AW = 6;
  localparam int PLO_DW = 64;
  localparam logic [5:0] PLO_OFS_P0 = 6'h00;
  localparam logic [5:0] PLO_OFS_P1 = 6'h08;
  localparam logic [5:0] PLO_OFS_BRG = 6'h10;
  localparam logic [5:0] PLO_OFS_CTRL = 6'h18;
  localparam logic [5:0] PLO_OFS_STAT = 6'h20;

  // ----------------------------------------------------------------
  // override register fields
  // ----------------------------------------------------------------
  localparam int PLO_EN_BIT = 0;
  localparam int PLO_SEC_BIT = 4;
  localparam int PLO_PID_LO = 8;
  localparam int PLO_PID_HI = 16;
  localparam int PLO_MON_BIT = 24;
  localparam logic [63:0] PLO_OVR_MASK = 64'h0000_0000_0101_ff11;
  localparam logic [63:0] PLO_OVR_RESET = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------
  // control and status fields
  // ----------------------------------------------------------------
  localparam int PLO_PASS_BIT = 0;
  localparam int PLO_BUILD_BIT = 1;
  localparam logic PLO_PASS_RESET = 1'b0;
  localparam logic PLO_FEATURE_BUILD = 1'b1;
  localparam int PLO_UNITS = 3;
  localparam int PLO_BRG_UNIT = 2;

  // ----------------------------------------------------------------
  // label carried on a request
  // ----------------------------------------------------------------
  localparam int PLO_PID_W = 9;
  typedef struct packed {
    logic monitor_group;
    logic [PLO_PID_W-1:0] partition_id;
    logic security;
  } plo_label_t;

endpackage : plo_pkg

// ==== plo_if.sv ====
// request and result bundle between the block and one label unit
`timescale 1ns/100ps
interface plo_if;
  import plo_pkg::*;
  logic in_valid;
  logic in_ns;
  plo_label_t in_label;
  logic fc;
  logic newest;
  logic [63:0] ovr;
  logic out_valid;
  logic out_ns;
  plo_label_t out_label;
  logic clamp;
  modport unit (
    input in_valid, in_ns, in_label, fc, newest, ovr,
    output out_valid, out_ns, out_label, clamp
  );
  modport host (
    output in_valid, in_ns, in_label, fc, newest, ovr,
    input out_valid, out_ns, out_label, clamp
  );
endinterface : plo_if

// ==== plo_apply.sv ====
// one label unit: substitutes, keeps or clamps the label of one request stream
`timescale 1ns/100ps
module plo_apply (
  input wire logic i_clock,
  input wire logic i_rst,
  plo_if.unit u
);
  import plo_pkg::*;

  typedef struct packed {
    logic valid;
    logic ns;
    plo_label_t label;
    logic clamp;
  } plo_apply_st_t;

  plo_apply_st_t q;
  plo_apply_st_t d;
  plo_label_t lbl;

  // ----------------------------------------------------------------
  // label selection
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    lbl = u.in_label;
    d.valid = u.in_valid;
    d.ns = u.in_ns;
    d.clamp = 1'b0;
    if (!PLO_FEATURE_BUILD) begin
      lbl = '0;
    end else if (u.fc) begin
      if (u.ovr[PLO_EN_BIT]) begin
        // register drives all fields, security included
        lbl.monitor_group = u.ovr[PLO_MON_BIT];
        lbl.partition_id = u.ovr[PLO_PID_HI:PLO_PID_LO];
        lbl.security = u.ovr[PLO_SEC_BIT];
      end else if (!u.newest) begin
        lbl = '0;
        lbl.security = u.in_ns;
      end
      // newest requester without override keeps its own label
      if (lbl.security && !u.in_ns) begin
        lbl.security = 1'b0;
        d.clamp = u.in_valid;
      end
    end
    // other requester types are not touched
    d.label = u.in_valid ? lbl : '0;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign u.out_valid = q.valid;
  assign u.out_ns = q.ns;
  assign u.out_label = q.label;
  assign u.clamp = q.clamp;

endmodule : plo_apply

// ==== plo_top.sv ====
// crosspoint partition-label override with bridge override and axi label pass
`timescale 1ns/100ps
module plo_top (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [plo_pkg::PLO_AW-1:0] i_reg_addr,
  input wire logic [plo_pkg::PLO_DW-1:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  output logic [plo_pkg::PLO_DW-1:0] o_reg_rdata,
  input wire logic [1:0] i_port_req_valid,
  input wire logic [1:0] i_port_req_ns,
  input wire plo_pkg::plo_label_t [1:0] i_port_req_label,
  input wire logic [1:0] i_port_is_fc,
  input wire logic [1:0] i_port_chi_newest,
  output logic [1:0] o_port_req_valid,
  output logic [1:0] o_port_req_ns,
  output plo_pkg::plo_label_t [1:0] o_port_req_label,
  input wire logic i_brg_req_valid,
  input wire logic i_brg_req_ns,
  input wire plo_pkg::plo_label_t i_brg_req_label,
  output logic o_brg_req_valid,
  output logic o_brg_req_ns,
  output plo_pkg::plo_label_t o_brg_req_label,
  input wire logic i_hn_req_valid,
  input wire plo_pkg::plo_label_t i_hn_req_label,
  output logic o_axi_label_valid,
  output plo_pkg::plo_label_t o_axi_label
);
  import plo_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PLO_UNITS-1:0][63:0] ovr;
    logic pass_en;
    logic [PLO_UNITS-1:0] clamp_seen;
    logic [63:0] rdata;
    logic axi_valid;
    plo_label_t axi_label;
  } plo_top_st_t;

  plo_top_st_t q;
  plo_top_st_t d;

  logic [PLO_UNITS-1:0] unit_valid;
  logic [PLO_UNITS-1:0] unit_ns;
  plo_label_t [PLO_UNITS-1:0] unit_label;
  logic [PLO_UNITS-1:0] unit_fc;
  logic [PLO_UNITS-1:0] unit_newest;
  logic [PLO_UNITS-1:0] res_valid;
  logic [PLO_UNITS-1:0] res_ns;
  plo_label_t [PLO_UNITS-1:0] res_label;
  logic [PLO_UNITS-1:0] res_clamp;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // maps an address to an override unit, PLO_UNITS when none
  function automatic logic [1:0] ovr_index(input logic [PLO_AW-1:0] addr);
    logic [1:0] idx;
    idx = 2'h3;
    case (addr)
      PLO_OFS_P0: idx = 2'h0;
      PLO_OFS_P1: idx = 2'h1;
      PLO_OFS_BRG: idx = 2'h2;
      default: idx = 2'h3;
    endcase
    return idx;
  endfunction : ovr_index

  // unmapped addresses read zero rather than stalling the master
  function automatic logic [63:0] read_word(input logic [PLO_AW-1:0] addr,
                                            input plo_top_st_t s);
    logic [63:0] w;
    logic [1:0] idx;
    w = 64'h0;
    idx = ovr_index(addr);
    if (idx != 2'h3) begin
      w = s.ovr[idx] & PLO_OVR_MASK;
    end else if (addr == PLO_OFS_CTRL) begin
      w[PLO_PASS_BIT] = s.pass_en;
      w[PLO_BUILD_BIT] = PLO_FEATURE_BUILD;
    end else if (addr == PLO_OFS_STAT) begin
      w[PLO_UNITS-1:0] = s.clamp_seen;
    end
    return w;
  endfunction : read_word

  // ----------------------------------------------------------------
  // label units: two device ports and the requester bridge
  // ----------------------------------------------------------------
  always_comb begin
    unit_valid = {i_brg_req_valid, i_port_req_valid};
    unit_ns = {i_brg_req_ns, i_port_req_ns};
    unit_label = {i_brg_req_label, i_port_req_label};
    // bridge override is its own and always applies to its own requests
    unit_fc = {1'b1, i_port_is_fc};
    unit_newest = {1'b1, i_port_chi_newest};
  end

  for (genvar g = 0; g < PLO_UNITS; g++) begin : g_unit
    plo_if lif ();
    assign lif.in_valid = unit_valid[g];
    assign lif.in_ns = unit_ns[g];
    assign lif.in_label = unit_label[g];
    assign lif.fc = unit_fc[g];
    assign lif.newest = unit_newest[g];
    // each unit sees only its own register
    assign lif.ovr = q.ovr[g];
    assign res_valid[g] = lif.out_valid;
    assign res_ns[g] = lif.out_ns;
    assign res_label[g] = lif.out_label;
    assign res_clamp[g] = lif.clamp;
    plo_apply u_apply (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .u(lif.unit)
    );
  end

  // ----------------------------------------------------------------
  // registers and axi label path
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] widx;
    widx = ovr_index(i_reg_addr);
    d = q;
    d.rdata = i_reg_read ? read_word(i_reg_addr, q) : 64'h0;
    if (i_reg_write) begin
      if (widx != 2'h3) begin
        d.ovr[widx] = i_reg_wdata & PLO_OVR_MASK;
      end else if (i_reg_addr == PLO_OFS_CTRL) begin
        d.pass_en = i_reg_wdata[PLO_PASS_BIT];
      end else if (i_reg_addr == PLO_OFS_STAT) begin
        d.clamp_seen = q.clamp_seen & ~i_reg_wdata[PLO_UNITS-1:0];
      end
    end
    // a clamp in the clearing cycle is kept
    d.clamp_seen = d.clamp_seen | res_clamp;
    d.axi_valid = i_hn_req_valid;
    // zeros on the axi pins when pass is off
    d.axi_label = (i_hn_req_valid && q.pass_en) ? i_hn_req_label : '0;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      q <= '0;
      q.pass_en <= PLO_PASS_RESET;
      q.ovr <= {PLO_UNITS{PLO_OVR_RESET}};
    end else begin
      q <= d;
    end
  end

  assign o_reg_rdata = q.rdata;
  assign o_port_req_valid = res_valid[1:0];
  assign o_port_req_ns = res_ns[1:0];
  assign o_port_req_label = res_label[1:0];
  assign o_brg_req_valid = res_valid[PLO_BRG_UNIT];
  assign o_brg_req_ns = res_ns[PLO_BRG_UNIT];
  assign o_brg_req_label = res_label[PLO_BRG_UNIT];
  assign o_axi_label_valid = q.axi_valid;
  assign o_axi_label = q.axi_label;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  property p_axi_zero;
    i_hn_req_valid && !q.pass_en |=> o_axi_label == '0;
  endproperty
  a_axi_zero: assert property (p_axi_zero) else $error("axi label not zero");

  property p_axi_pass;
    i_hn_req_valid && q.pass_en |=> o_axi_label == $past(i_hn_req_label) && o_axi_label_valid;
  endproperty
  a_axi_pass: assert property (p_axi_pass) else $error("axi label not passed");

  property p_rsvd_zero;
    i_reg_read && ovr_index(i_reg_addr) != 2'h3 |=> (o_reg_rdata & ~PLO_OVR_MASK) == 64'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

  property p_layout;
    i_reg_write && i_reg_addr == PLO_OFS_P0 ##1 i_reg_read && i_reg_addr == PLO_OFS_P0
      |=> o_reg_rdata == ($past(i_reg_wdata, 2) & PLO_OVR_MASK);
  endproperty
  a_layout: assert property (p_layout) else $error("override readback wrong");

  property p_port_sep;
    i_reg_write && i_reg_addr == PLO_OFS_P1 |=> $stable(q.ovr[0]);
  endproperty
  a_port_sep: assert property (p_port_sep) else $error("port 0 register disturbed");

  // only coherent requesters are clamped; other device types pass untouched
  property p_clamp;
    i_port_req_valid[0] && i_port_is_fc[0]
      |=> !(o_port_req_label[0].security && !o_port_req_ns[0]);
  endproperty
  a_clamp: assert property (p_clamp) else $error("security not clamped");

  property p_old_clear;
    i_port_req_valid[0] && i_port_is_fc[0] && !i_port_chi_newest[0] && !q.ovr[0][PLO_EN_BIT]
      |=> o_port_req_label[0].partition_id == '0 && !o_port_req_label[0].monitor_group
          && o_port_req_label[0].security == $past(i_port_req_ns[0]);
  endproperty
  a_old_clear: assert property (p_old_clear) else $error("old requester label wrong");

  property p_ovr_fields;
    i_port_req_valid[1] && i_port_is_fc[1] && q.ovr[1][PLO_EN_BIT]
      |=> o_port_req_label[1].partition_id == $past(q.ovr[1][PLO_PID_HI:PLO_PID_LO])
          && o_port_req_label[1].monitor_group == $past(q.ovr[1][PLO_MON_BIT]);
  endproperty
  a_ovr_fields: assert property (p_ovr_fields) else $error("override not applied");

  property p_ovr_sec;
    i_port_req_valid[0] && i_port_is_fc[0] && i_port_req_ns[0] && q.ovr[0][PLO_EN_BIT]
      |=> o_port_req_label[0].security == $past(q.ovr[0][PLO_SEC_BIT]);
  endproperty
  a_ovr_sec: assert property (p_ovr_sec) else $error("security override wrong");

  property p_new_pass;
    i_port_req_valid[0] && i_port_is_fc[0] && i_port_chi_newest[0] && i_port_req_ns[0]
      && !q.ovr[0][PLO_EN_BIT] |=> o_port_req_label[0] == $past(i_port_req_label[0]);
  endproperty
  a_new_pass: assert property (p_new_pass) else $error("newest label altered");

  property p_non_fc;
    i_port_req_valid[1] && !i_port_is_fc[1] |=> o_port_req_label[1] == $past(i_port_req_label[1]);
  endproperty
  a_non_fc: assert property (p_non_fc) else $error("non coherent label altered");

  property p_brg;
    i_brg_req_valid && q.ovr[PLO_BRG_UNIT][PLO_EN_BIT]
      |=> o_brg_req_label.partition_id == $past(q.ovr[PLO_BRG_UNIT][PLO_PID_HI:PLO_PID_LO]);
  endproperty
  a_brg: assert property (p_brg) else $error("bridge override not applied");

  property p_old_ovr;
    i_port_req_valid[0] && i_port_is_fc[0] && !i_port_chi_newest[0] && q.ovr[0][PLO_EN_BIT]
      |=> o_port_req_label[0].partition_id == $past(q.ovr[0][PLO_PID_HI:PLO_PID_LO]);
  endproperty
  a_old_ovr: assert property (p_old_ovr) else $error("old requester override wrong");

  property p_sticky;
    res_clamp[0] |=> q.clamp_seen[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("clamp event lost");

  property p_fwd;
    i_port_req_valid[0] |=> o_port_req_valid[0] ##0 o_port_req_ns[0] == $past(i_port_req_ns[0]);
  endproperty
  a_fwd: assert property (p_fwd) else $error("request not forwarded");

  c_clamp: cover property (res_clamp[0]);
  c_ovr: cover property (i_port_req_valid[0] && i_port_is_fc[0] && q.ovr[0][PLO_EN_BIT]);
  c_axi: cover property (i_hn_req_valid && q.pass_en);
  c_brg: cover property (i_brg_req_valid && q.ovr[PLO_BRG_UNIT][PLO_EN_BIT]);

endmodule : plo_top

// ==== plo_req_model.sv ====
// requester model on one crosspoint device port, fully coherent when i_fc is set
`timescale 1ns/100ps
module plo_req_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic i_ns,
  input wire plo_pkg::plo_label_t i_label,
  input wire logic i_fc,
  input wire logic i_newest,
  output logic o_valid,
  output logic o_ns,
  output plo_pkg::plo_label_t o_label,
  output logic o_fc,
  output logic o_newest
);
  import plo_pkg::*;
  // ----------------------------------------------------------------
  // request launch
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_ns <= 1'b0;
      o_label <= '0;
      o_fc <= 1'b0;
      o_newest <= 1'b0;
    end else begin
      o_fc <= i_fc;
      o_newest <= i_newest;
      o_valid <= i_go;
      if (i_go) begin
        o_ns <= i_ns;
        o_label <= i_label;
      end else begin
        // idle lines flip so a stale flit never looks like a fresh one
        o_ns <= ~o_ns;
        o_label <= ~o_label;
      end
    end
  end
endmodule : plo_req_model

// ==== plo_top_test.sv ====
// self-checking bench for the partition-label override block
`timescale 1ns/100ps
module plo_top_test;
  import plo_pkg::*;
  typedef struct packed {logic v; logic ns; plo_label_t l;} plo_exp_t;
  logic clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pass = 1'b0;
  logic [PLO_AW-1:0] addr = '0;
  logic [63:0] wdata = '0, rdata, got;
  logic [1:0] go = '0, ns_in = '0, fc_in = '0, nw_in = '0, o_valid, o_ns;
  plo_label_t [1:0] lbl_in = '0, o_lbl;
  wire [1:0] p_valid, p_ns, p_fc, p_nw;
  wire plo_label_t [1:0] p_lbl;
  logic b_valid = 1'b0, b_ns = 1'b0, h_valid = 1'b0, ob_valid, ob_ns, ax_valid;
  plo_label_t b_lbl = '0, h_lbl = '0, ob_lbl, ax_lbl;
  logic [63:0] ovr [3];
  logic [5:0] offs [6] = '{PLO_OFS_P0, PLO_OFS_P1, PLO_OFS_BRG, PLO_OFS_CTRL, PLO_OFS_STAT, 6'h28};
  int failures = 0, checks_done = 0, cycles = 0;
  logic [31:0] seed = 32'hdb02af11;
  plo_exp_t pq [2][$];
  plo_exp_t bx = '0, hx = '0;
  logic [2:0] mclamp = '0;

  for (genvar g = 0; g < 2; g++) begin : g_req
    plo_req_model u_req (.i_clock(clock), .i_rst(rst), .i_go(go[g]), .i_ns(ns_in[g]),
      .i_label(lbl_in[g]), .i_fc(fc_in[g]), .i_newest(nw_in[g]), .o_valid(p_valid[g]),
      .o_ns(p_ns[g]), .o_label(p_lbl[g]), .o_fc(p_fc[g]), .o_newest(p_nw[g]));
  end
  plo_top dut (.i_clock(clock), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_write(wr), .i_reg_read(rd), .o_reg_rdata(rdata), .i_port_req_valid(p_valid),
    .i_port_req_ns(p_ns), .i_port_req_label(p_lbl), .i_port_is_fc(p_fc),
    .i_port_chi_newest(p_nw), .o_port_req_valid(o_valid), .o_port_req_ns(o_ns),
    .o_port_req_label(o_lbl), .i_brg_req_valid(b_valid), .i_brg_req_ns(b_ns),
    .i_brg_req_label(b_lbl), .o_brg_req_valid(ob_valid), .o_brg_req_ns(ob_ns),
    .o_brg_req_label(ob_lbl), .i_hn_req_valid(h_valid), .i_hn_req_label(h_lbl),
    .o_axi_label_valid(ax_valid), .o_axi_label(ax_lbl));

  // ----------------------------------------------------------------
  // clock, timeout, helpers
  // ----------------------------------------------------------------
  always #5 clock = ~clock;
  // whole run needs about 1630 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end

  function automatic logic [31:0] next_rand();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
    return seed;
  endfunction : next_rand

  function automatic plo_label_t exp_lbl(logic fc, logic nw, logic [63:0] r, logic ns,
                                         plo_label_t li);
    plo_label_t x;
    x = li;
    if (!fc) return li;
    if (r[0]) x = {r[24], r[16:8], r[4]};
    else if (!nw) x = {1'b0, 9'h000, ns};
    if (!ns) x.security = 1'b0;
    if (!PLO_FEATURE_BUILD) x = '0;
    return x;
  endfunction : exp_lbl

  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_wr(logic [5:0] a, logic [63:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(logic [5:0] a, output logic [63:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  // random requests on all paths, last cycles idle to drain
  task automatic traffic(int n);
    logic [31:0] r, s;
    plo_exp_t e;
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      for (int p = 0; p < 2; p++) begin
        r = next_rand();
        go[p] <= (i < n - 2) && r[0];
        ns_in[p] <= r[1];
        fc_in[p] <= r[2] | r[3];
        nw_in[p] <= r[4];
        lbl_in[p] <= r[15:5];
        e = '{(i < n - 2) && r[0], r[1], '0};
        if (e.v) e.l = exp_lbl(r[2] | r[3], r[4], ovr[p], r[1], r[15:5]);
        if (e.v && (r[2] | r[3]) && !r[1] && (ovr[p][0] ? ovr[p][4] : r[4] && r[5]))
          mclamp[p] = 1'b1;
        pq[p].push_back(e);
      end
      s = next_rand();
      b_valid <= (i < n - 1) && s[0];
      b_ns <= s[1];
      b_lbl <= s[12:2];
      h_valid <= (i < n - 1) && s[13];
      h_lbl <= s[24:14];
      #1;
      for (int p = 0; p < 2; p++) begin
        e = pq[p].pop_front();
        check("port valid", o_valid[p], e.v);
        check("port label", o_lbl[p], e.l);
        if (e.v) check("port ns", o_ns[p], e.ns);
      end
      check("bridge valid", ob_valid, bx.v);
      if (bx.v) check("bridge label", ob_lbl, bx.l);
      if (bx.v) check("bridge ns", ob_ns, bx.ns);
      check("axi valid", ax_valid, hx.v);
      if (hx.v) check("axi label", ax_lbl, hx.l);
      if ((i < n - 1) && s[0] && !s[1] && (ovr[2][0] ? ovr[2][4] : s[2]))
        mclamp[2] = 1'b1;
      bx = '{(i < n - 1) && s[0], s[1], exp_lbl(1'b1, 1'b1, ovr[2], s[1], s[12:2])};
      hx = '{(i < n - 1) && s[13], 1'b0, pass ? plo_label_t'(s[24:14]) : plo_label_t'(0)};
    end
  endtask : traffic

  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [63:0] w;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      reg_rd(offs[k], got);
      check("reset value", got, (k == 3) ? 64'(PLO_FEATURE_BUILD) << 1 : 64'h0);
    end
    $display("test reset_values done");
    reg_wr(PLO_OFS_P0, '1);
    reg_wr(6'h28, '1);
    reg_rd(PLO_OFS_P0, got);
    check("override mask", got, 64'h0000_0000_0101_ff11);
    reg_rd(6'h28, got);
    check("unmapped read", got, 64'h0);
    $display("test reserved_bits done");
    for (int k = 0; k < 3; k++) ovr[k] = '0;
    for (int k = 0; k < 3; k++) reg_wr(offs[k], 64'h0);
    for (int p = 0; p < 2; p++) pq[p] = '{'0, '0};
    for (int it = 0; it < 40; it++) begin
      for (int k = 0; k < 3; k++) begin
        w = {next_rand(), next_rand()};
        ovr[k] = w & 64'h0000_0000_0101_ff11;
        reg_wr(offs[k], w & ~64'h1);
        reg_wr(offs[k], w);
        reg_rd(offs[k], got);
        check("override readback", got, ovr[k]);
      end
      w = {next_rand(), next_rand()};
      pass = w[0];
      reg_wr(PLO_OFS_CTRL, w);
      reg_rd(PLO_OFS_CTRL, got);
      check("control readback", got, {62'h0, PLO_FEATURE_BUILD, w[0]});
      traffic(12);
      // sticky clamp flags, then write one to clear
      reg_rd(PLO_OFS_STAT, got);
      check("clamp status", got, 64'(mclamp));
      reg_wr(PLO_OFS_STAT, 64'h7);
      mclamp = '0;
      reg_rd(PLO_OFS_STAT, got);
      check("clamp cleared", got, 64'h0);
    end
    $display("test label_traffic done");
    close_out();
  end
endmodule : plo_top_test
